// ### count_divider.sv
`default_nettype none
module count_divider
  import pulse_width_capture_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  output logic      tick_fast_o,
  output logic      tick_slow_o
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       fast;
    logic       slow;
  } div_state_t;

  div_state_t st_reg;
  div_state_t st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.cnt  = st_reg.cnt + 4'h1;
    st_next.fast = (st_reg.cnt[1:0] == DIV_FAST_LAST[1:0]);
    st_next.slow = (st_reg.cnt == DIV_SLOW_LAST);
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick_fast_o = st_reg.fast;
  assign tick_slow_o = st_reg.slow;
endmodule
`default_nettype wire

// ### edge_event_if.sv
`default_nettype none
interface edge_event_if;
  logic rise;
  logic fall;
  modport src (output rise, output fall);
  modport dst (input rise, input fall);
endinterface
`default_nettype wire

// ### edge_filter.sv
`default_nettype none
module edge_filter (
  input  wire logic   clk_sys_i,
  input  wire logic   reset_i,
  input  wire logic   sample_en_i,
  input  wire logic   pin_i,
  edge_event_if.src   ev
);
  typedef struct packed {
    logic samp;
    logic level;
    logic rise;
    logic fall;
  } filt_state_t;

  filt_state_t st_reg;
  filt_state_t st_next;

  // level moves only when two consecutive samples agree on the new value
  always_comb begin
    st_next      = st_reg;
    st_next.rise = 1'b0;
    st_next.fall = 1'b0;
    if (sample_en_i) begin
      st_next.samp = pin_i;
      if ((pin_i == st_reg.samp) && (pin_i != st_reg.level)) begin // RQ4
        st_next.level = pin_i;
        st_next.rise  = pin_i;
        st_next.fall  = !pin_i;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ev.rise = st_reg.rise;
  assign ev.fall = st_reg.fall;

  level_two_samples_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RQ4
    $changed(st_reg.level) |-> $past(sample_en_i) && ($past(pin_i) == $past(st_reg.samp)))
    else $error("filtered level changed without two equal samples");
endmodule
`default_nettype wire

// ### pulse_source_model.sv
`default_nettype none
module pulse_source_model (
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  input  wire logic level_a_i,
  input  wire logic level_b_i,
  output logic      pin_a_o,
  output logic      pin_b_o,
  output logic      tick_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] phase;
  // ---------------------------------------------------------------
  // pulse sources and the foreign timer tick
  // ---------------------------------------------------------------
  // levels move only when commanded, so a short pulse is always on purpose
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pin_a_o <= 1'b0;
      pin_b_o <= 1'b0;
      phase   <= 3'h0;
      tick_o  <= 1'b0;
    end else begin
      pin_a_o <= level_a_i;
      pin_b_o <= level_b_i;
      phase   <= phase + 3'h1;
      tick_o  <= (phase == 3'h7);
    end
  end
endmodule
`default_nettype wire

// ### pulse_width_capture.sv
// Operation
// RQ1 - counter runs free or restarts on each valid edge of input a
// RQ2 - free running: valid edge of input a loads register b, raises irq b
// RQ3 - input a valid edge chosen by prescaler mode bits 4 and 5
// RQ4 - inputs sampled at count clock; two equal samples needed before capture (when counting input a edges the code samples at the system clock)
// RQ5 - valid edge of input b loads register a, raises irq a
// RQ6 - two-register mode: b on selected edge, a on opposite edge of input a
// RQ7 - software picks only rising or falling edge for two-register or restart
// RQ8 - both edges selected in opposite-edge mode: register a never captures
// RQ9 - restart: valid edge loads register b, then counter clears and resumes
// RQ10 - edge code 00 falling, 01 rising, 11 both, 10 prohibited
// RQ11 - trigger bit: 0 input b edge, 1 opposite edge of input a
// RQ12 - mode bit 0 compare register, 1 capture register
// RQ13 - count clock: clock/4, clock/16, timer output, valid edge of input a
// RQ14 - capture and irq follow the filter delay, not the raw edge
// RQ15 - capture register holds its value until the next capture
//
// The APB register port and the placing of the registers were left to the implementer.
`default_nettype none
module pulse_width_capture
  import pulse_width_capture_pkg::*;
#(
  parameter int COUNT_W = 16
) (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        edge_input_a_i,
  input  wire logic        edge_input_b_i,
  input  wire logic        clock_timer_output_i,
  output logic             capture_a_irq_o,
  output logic             capture_b_irq_o,
  output logic             irq_o
);
  if (COUNT_W < 2 || COUNT_W > 32) begin : g_width_check
    $error("COUNT_W must lie between 2 and 32");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [COUNT_W-1:0] main_counter;
    logic [COUNT_W-1:0] cap_a;
    logic [COUNT_W-1:0] cap_b;
    run_mode_t          mode;
    logic [2:0]         capture_ctrl;
    logic [7:0]         prescaler_mode;
    logic [2:0]         status;
    logic [2:0]         mask;
    logic               irq_a;
    logic               irq_b;
    logic [31:0]        rdata;
  } top_state_t;

  top_state_t st_reg;
  top_state_t st_next;

  logic       tick_fast;
  logic       tick_slow;
  logic       tick_sel;
  logic       sample_en;
  logic       count_en;
  logic [1:0] clk_sel;
  logic [1:0] es_a;
  logic [1:0] es_b;
  logic       running;
  logic       valid_a;
  logic       opposite_a;
  logic       valid_b;
  logic       cap_a_ev;
  logic       cap_b_ev;
  logic       restart_ev;
  logic       cmp_a_ev;
  logic       cmp_b_ev;
  logic       ovf_ev;
  logic       addr_ok;
  logic       wr_acc;
  logic       rd_status;
  logic [2:0] events;

  edge_event_if ev_a ();
  edge_event_if ev_b ();

  // ---------------------------------------------------------------
  // count clock and input filters
  // ---------------------------------------------------------------
  count_divider u_div (
    .clk_sys_i   (clk_sys_i),
    .reset_i     (reset_i),
    .tick_fast_o (tick_fast),
    .tick_slow_o (tick_slow)
  );

  assign clk_sel = st_reg.prescaler_mode[COUNT_CLK_SEL_LO +: 2];
  assign es_a    = st_reg.prescaler_mode[EDGE_SEL_A_LO +: 2];
  assign es_b    = st_reg.prescaler_mode[EDGE_SEL_B_LO +: 2];

  always_comb begin
    unique case (clk_sel) // RQ13
      CLK_DIV_FAST:  tick_sel = tick_fast;
      CLK_DIV_SLOW:  tick_sel = tick_slow;
      CLK_TIMER_OUT: tick_sel = clock_timer_output_i;
      CLK_EDGE_A:    tick_sel = 1'b1;
    endcase
  end

  // counting on input a edges samples at the system clock instead
  assign sample_en = tick_sel; // RQ4
  assign count_en  = (clk_sel == CLK_EDGE_A) ? valid_a : tick_sel; // RQ13

  edge_filter u_filt_a (
    .clk_sys_i   (clk_sys_i),
    .reset_i     (reset_i),
    .sample_en_i (sample_en),
    .pin_i       (edge_input_a_i),
    .ev          (ev_a)
  );

  edge_filter u_filt_b (
    .clk_sys_i   (clk_sys_i),
    .reset_i     (reset_i),
    .sample_en_i (sample_en),
    .pin_i       (edge_input_b_i),
    .ev          (ev_b)
  );

  // ---------------------------------------------------------------
  // edge qualification
  // ---------------------------------------------------------------
  // code 10 is prohibited and simply yields no valid edge
  always_comb begin
    valid_a    = ((es_a == EDGE_RISE) && ev_a.rise) // RQ3 RQ10
              || ((es_a == EDGE_FALL) && ev_a.fall)
              || ((es_a == EDGE_BOTH) && (ev_a.rise || ev_a.fall));
    opposite_a = ((es_a == EDGE_RISE) && ev_a.fall) // RQ6 RQ8
              || ((es_a == EDGE_FALL) && ev_a.rise);
    valid_b    = ((es_b == EDGE_RISE) && ev_b.rise) // RQ10
              || ((es_b == EDGE_FALL) && ev_b.fall)
              || ((es_b == EDGE_BOTH) && (ev_b.rise || ev_b.fall));
  end

  assign running    = (st_reg.mode == MODE_FREE) || (st_reg.mode == MODE_RESTART); // RQ1
  assign restart_ev = running && (st_reg.mode == MODE_RESTART) && valid_a; // RQ9
  assign cap_b_ev   = running && valid_a // RQ2 RQ9
                   && (st_reg.capture_ctrl[REG_B_CAPTURE_MODE] || restart_ev);
  assign cap_a_ev   = running && st_reg.capture_ctrl[REG_A_CAPTURE_MODE] // RQ12
                   && (st_reg.capture_ctrl[REG_A_TRIGGER_SEL] ? opposite_a : valid_b); // RQ5 RQ11
  assign cmp_a_ev   = running && count_en && !st_reg.capture_ctrl[REG_A_CAPTURE_MODE]
                   && (st_reg.main_counter == st_reg.cap_a);
  assign cmp_b_ev   = running && count_en && !st_reg.capture_ctrl[REG_B_CAPTURE_MODE]
                   && (st_reg.main_counter == st_reg.cap_b);
  assign ovf_ev     = running && count_en && !restart_ev && (&st_reg.main_counter);

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  always_comb begin
    unique case (paddr)
      ADDR_TIMER_MODE_CTRL, ADDR_CAPTURE_CTRL, ADDR_PRESCALER_MODE,
      ADDR_CAPTURE_COMPARE_A, ADDR_CAPTURE_COMPARE_B, ADDR_MAIN_COUNTER,
      ADDR_IRQ_STATUS, ADDR_IRQ_MASK: addr_ok = 1'b1;
      default:                         addr_ok = 1'b0;
    endcase
  end

  assign wr_acc    = psel && penable && pwrite && addr_ok;
  assign rd_status = psel && penable && !pwrite && (paddr == ADDR_IRQ_STATUS);
  assign events    = {ovf_ev, cap_b_ev || cmp_b_ev, cap_a_ev || cmp_a_ev};

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next       = st_reg;
    st_next.irq_a = cap_a_ev || cmp_a_ev; // RQ14
    st_next.irq_b = cap_b_ev || cmp_b_ev; // RQ14

    if (!running) begin
      st_next.main_counter = '0;
    end else if (restart_ev) begin
      st_next.main_counter = '0; // RQ9
    end else if (count_en) begin
      st_next.main_counter = st_reg.main_counter + 1'b1; // RQ1
    end

    // capture and software write share a register; capture wins
    if (cap_a_ev) begin
      st_next.cap_a = st_reg.main_counter; // RQ5 RQ6 RQ15
    end else if (wr_acc && (paddr == ADDR_CAPTURE_COMPARE_A)
                 && !st_reg.capture_ctrl[REG_A_CAPTURE_MODE]) begin
      st_next.cap_a = pwdata[COUNT_W-1:0]; // RQ12
    end
    if (cap_b_ev) begin
      st_next.cap_b = st_reg.main_counter; // RQ2 RQ9 RQ15
    end else if (wr_acc && (paddr == ADDR_CAPTURE_COMPARE_B)
                 && !st_reg.capture_ctrl[REG_B_CAPTURE_MODE]) begin
      st_next.cap_b = pwdata[COUNT_W-1:0]; // RQ12
    end

    if (wr_acc) begin
      unique case (paddr)
        ADDR_TIMER_MODE_CTRL: begin
          st_next.mode = (pwdata[1:0] == 2'h3) ? MODE_STOP : run_mode_t'(pwdata[1:0]);
        end
        ADDR_CAPTURE_CTRL:   st_next.capture_ctrl   = pwdata[2:0];
        ADDR_PRESCALER_MODE: st_next.prescaler_mode = pwdata[7:0];
        ADDR_IRQ_MASK:       st_next.mask           = pwdata[2:0];
        default: ;
      endcase
    end

    // a new event in the clearing cycle survives the read; only bits already read are cleared
    st_next.status = (st_reg.status & ~(st_reg.rdata[2:0] & {3{rd_status}})) | events;

    if (psel && !penable) begin
      unique case (paddr)
        ADDR_TIMER_MODE_CTRL:   st_next.rdata = {30'h0000_0000, st_reg.mode};
        ADDR_CAPTURE_CTRL:      st_next.rdata = {29'h0000_0000, st_reg.capture_ctrl};
        ADDR_PRESCALER_MODE:    st_next.rdata = {24'h00_0000, st_reg.prescaler_mode};
        ADDR_CAPTURE_COMPARE_A: st_next.rdata = 32'(st_reg.cap_a);
        ADDR_CAPTURE_COMPARE_B: st_next.rdata = 32'(st_reg.cap_b);
        ADDR_MAIN_COUNTER:      st_next.rdata = 32'(st_reg.main_counter);
        ADDR_IRQ_STATUS:        st_next.rdata = {29'h0000_0000, st_reg.status};
        ADDR_IRQ_MASK:          st_next.rdata = {29'h0000_0000, st_reg.mask};
        default:                st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      st_reg                <= '0;
      st_reg.mode           <= MODE_STOP;
      st_reg.capture_ctrl   <= CAPTURE_CTRL_RESET;
      st_reg.prescaler_mode <= PRESCALER_MODE_RESET;
      st_reg.mask           <= IRQ_MASK_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata          = st_reg.rdata;
  assign pready          = 1'b1;
  assign pslverr         = psel && penable && !addr_ok;
  assign capture_a_irq_o = st_reg.irq_a;
  assign capture_b_irq_o = st_reg.irq_b;
  assign irq_o           = |(st_reg.status & st_reg.mask);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  free_count_a: assert property ( // RQ1
    running && count_en && !restart_ev |=> st_reg.main_counter == $past(st_reg.main_counter) + 1'b1)
    else $error("counter did not advance on count enable");
  div_hold_a: assert property ( // RQ13
    running && (clk_sel == CLK_DIV_FAST) && !tick_fast && !restart_ev
    |=> $stable(st_reg.main_counter))
    else $error("counter moved without a divided tick");
  cap_b_load_a: assert property ( // RQ2
    cap_b_ev |=> st_reg.cap_b == $past(st_reg.main_counter) && capture_b_irq_o
                 && st_reg.status[STAT_CAPTURE_B])
    else $error("register b capture or irq missing");
  edge_sel_a: assert property ( // RQ3
    (es_a == EDGE_FALL) && ev_a.rise && !ev_a.fall |-> !valid_a)
    else $error("rising edge accepted while falling selected");
  input_b_cap_a: assert property ( // RQ5
    running && st_reg.capture_ctrl[REG_A_CAPTURE_MODE]
    && !st_reg.capture_ctrl[REG_A_TRIGGER_SEL] && valid_b
    |=> st_reg.cap_a == $past(st_reg.main_counter) ##1 !capture_a_irq_o || cap_a_ev || cmp_a_ev)
    else $error("input b edge did not capture into register a");
  opposite_cap_a: assert property ( // RQ6
    running && (st_reg.capture_ctrl[1:0] == 2'b11) && (es_a == EDGE_RISE) && ev_a.fall
    |=> st_reg.cap_a == $past(st_reg.main_counter) && capture_a_irq_o)
    else $error("opposite edge did not capture into register a");
  both_no_a_a: assert property ( // RQ8
    (st_reg.capture_ctrl[1:0] == 2'b11) && (es_a == EDGE_BOTH) |=> $stable(st_reg.cap_a))
    else $error("register a captured with both edges selected");
  restart_clr_a: assert property ( // RQ9
    restart_ev |=> st_reg.main_counter == '0 && st_reg.cap_b == $past(st_reg.main_counter))
    else $error("restart did not capture then clear");
  cmp_write_a: assert property ( // RQ12
    wr_acc && (paddr == ADDR_CAPTURE_COMPARE_A) && !cap_a_ev
    |=> st_reg.cap_a == ($past(st_reg.capture_ctrl[REG_A_CAPTURE_MODE])
                         ? $past(st_reg.cap_a) : $past(pwdata[COUNT_W-1:0])))
    else $error("register a write mishandled for its mode");
  cap_hold_a: assert property ( // RQ15
    !cap_a_ev && !wr_acc |=> $stable(st_reg.cap_a))
    else $error("register a changed without a capture");

  restart_c: cover property (restart_ev ##[1:100] restart_ev);
  opposite_c: cover property (cap_b_ev ##[1:100] cap_a_ev);
  irq_c: cover property (irq_o ##1 rd_status ##1 !irq_o);
endmodule
`default_nettype wire

// ### pulse_width_capture_pkg.sv
`default_nettype none
package pulse_width_capture_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses on apb)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_TIMER_MODE_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_CAPTURE_CTRL      = 8'h04;
  localparam logic [7:0] ADDR_PRESCALER_MODE    = 8'h08;
  localparam logic [7:0] ADDR_CAPTURE_COMPARE_A = 8'h0C;
  localparam logic [7:0] ADDR_CAPTURE_COMPARE_B = 8'h10;
  localparam logic [7:0] ADDR_MAIN_COUNTER      = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STATUS        = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK          = 8'h1C;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int REG_A_CAPTURE_MODE = 0;
  localparam int REG_A_TRIGGER_SEL  = 1;
  localparam int REG_B_CAPTURE_MODE = 2;
  localparam int COUNT_CLK_SEL_LO   = 0;
  localparam int EDGE_SEL_A_LO      = 4;
  localparam int EDGE_SEL_B_LO      = 6;
  localparam int STAT_CAPTURE_A     = 0;
  localparam int STAT_CAPTURE_B     = 1;
  localparam int STAT_OVERFLOW      = 2;
  localparam logic [2:0] CAPTURE_CTRL_RESET   = 3'h0;
  localparam logic [7:0] PRESCALER_MODE_RESET = 8'h00;
  localparam logic [2:0] IRQ_MASK_RESET       = 3'h0;

  // ---------------------------------------------------------------
  // encodings and cycle counts
  // ---------------------------------------------------------------
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [1:0] CLK_DIV_FAST  = 2'h0;
  localparam logic [1:0] CLK_DIV_SLOW  = 2'h1;
  localparam logic [1:0] CLK_TIMER_OUT = 2'h2;
  localparam logic [1:0] CLK_EDGE_A    = 2'h3;
  localparam logic [3:0] DIV_FAST_LAST = 4'h3;
  localparam logic [3:0] DIV_SLOW_LAST = 4'hF;

  typedef enum logic [1:0] {
    MODE_STOP    = 2'b00,
    MODE_FREE    = 2'b01,
    MODE_RESTART = 2'b10
  } run_mode_t;
endpackage
`default_nettype wire

// ### test_pulse_width_capture.sv
`default_nettype none
module test_pulse_width_capture
  import pulse_width_capture_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr, pin_a, pin_b, tick, irq_a, irq_b, irq;
  logic        level_a = 1'b0;
  logic        level_b = 1'b0;
  logic [15:0] tick_cnt = 16'h0000;
  logic [15:0] base, last_b;
  logic [31:0] seed = 32'h0000_98f1;
  int          error_cnt = 0;
  int          n_tests = 0;
  logic [33:0] rd_q[$];
  logic [1:0]  ev_q[$];
  logic [1:0]  code_a, code_b, mask;
  logic        trig, restart;
  logic [1:0]  codes [4] = '{EDGE_FALL, EDGE_RISE, EDGE_BOTH, 2'h2};

  always #4 clk_sys_i = ~clk_sys_i;

  pulse_width_capture dut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .edge_input_a_i(pin_a), .edge_input_b_i(pin_b),
    .clock_timer_output_i(tick), .capture_a_irq_o(irq_a), .capture_b_irq_o(irq_b),
    .irq_o(irq));
  pulse_source_model src (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .level_a_i(level_a), .level_b_i(level_b),
    .pin_a_o(pin_a), .pin_b_o(pin_b), .tick_o(tick));

  // ---------------------------------------------------------------
  // reporting
  // ---------------------------------------------------------------
  task automatic results();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [33:0] exp, input logic [33:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic timeout();
    error_cnt++;
    $display("unexpected wait: expected handshake seen none");
    results();
  endtask
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // ---------------------------------------------------------------
  // monitor: results against the oldest note
  // ---------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (tick === 1'b1) begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      check("read", rd_q.size() > 0 ? rd_q.pop_front() : '1, {irq, pslverr, prdata});
    end
    if (irq_a === 1'b1 || irq_b === 1'b1) begin
      check("capture irq", {32'h0000_0000, ev_q.size() > 0 ? ev_q.pop_front() : 2'b00},
            {32'h0000_0000, irq_b, irq_a});
    end
  end

  // ---------------------------------------------------------------
  // drivers
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys_i);
      if (pready === 1'b1) break;
    end
    if (i == 20) timeout();
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] exp);
    rd_q.push_back(exp);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic wait_tick();
    int i;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_sys_i);
      if (tick === 1'b1) break;
    end
    if (i == 40) timeout();
  endtask
  // write just after a tick, so no count lands on the mode change edge
  task automatic set_mode(input logic [1:0] m);
    wait_tick();
    apb(1'b1, ADDR_TIMER_MODE_CTRL, {30'h0000_0000, m});
    base = tick_cnt;
  endtask
  function automatic logic hit(input logic [1:0] code, input logic lvl);
    return (code == EDGE_BOTH) || (code == EDGE_RISE && lvl) || (code == EDGE_FALL && !lvl);
  endfunction
  task automatic step(input logic pin, input logic lvl);
    logic [1:0]  ev;
    logic [15:0] val;
    logic        q;
    int          n;
    n = xs() % 3;
    repeat (n + 1) wait_tick();
    if (pin) level_b <= lvl;
    else level_a <= lvl;
    ev[1] = !pin && hit(code_a, lvl);
    ev[0] = pin ? (!trig && hit(code_b, lvl))
                : (trig && code_a != EDGE_BOTH && hit(code_a, !lvl));
    q = |(ev & mask);
    if (ev != 2'b00) ev_q.push_back(ev);
    @(posedge clk_sys_i);
    val = tick_cnt + 16'h0002 - base;
    repeat (3) wait_tick();
    if (ev[1]) rd(ADDR_CAPTURE_COMPARE_B, {q, 17'h0_0000, val});
    if (ev[0]) rd(ADDR_CAPTURE_COMPARE_A, {q, 17'h0_0000, val});
    rd(ADDR_IRQ_STATUS, {q, 31'h0000_0000, ev});
    if (ev[1]) last_b = val;
    if (restart && ev[1]) base = base + val;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    mask = 2'b10;
    trig = 1'b0;
    restart = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rd(ADDR_CAPTURE_CTRL, 34'h0_0000_0000);
    rd(ADDR_PRESCALER_MODE, 34'h0_0000_0000);
    rd(ADDR_MAIN_COUNTER, 34'h0_0000_0000);
    rd(8'h20, 34'h1_0000_0000);
    // compare mode: counter reaching register b raises its irq
    apb(1'b1, ADDR_PRESCALER_MODE, 32'h0000_0012);
    apb(1'b1, ADDR_CAPTURE_COMPARE_B, 32'h0000_0003);
    apb(1'b1, ADDR_CAPTURE_COMPARE_A, 32'h0000_ffff);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0002);
    ev_q.push_back(2'b10);
    set_mode(MODE_FREE);
    repeat (8) wait_tick();
    rd(ADDR_CAPTURE_COMPARE_B, 34'h2_0000_0003);
    rd(ADDR_IRQ_STATUS, 34'h2_0000_0002);
    set_mode(MODE_STOP);
    for (int t = 0; t < 2; t++) begin
      trig = t[0];
      mask = {1'b1, t[0]};
      apb(1'b1, ADDR_IRQ_MASK, {30'h0000_0000, mask});
      apb(1'b1, ADDR_CAPTURE_CTRL, {29'h0000_0000, 1'b1, trig, 1'b1});
      set_mode(MODE_FREE);
      for (int k = 0; k < 4; k++) begin
        code_a = codes[k];
        code_b = codes[3 - k];
        apb(1'b1, ADDR_PRESCALER_MODE, {24'h00_0000, code_b, code_a, 4'h2});
        step(1'b0, 1'b1);
        step(1'b0, 1'b0);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
      end
      set_mode(MODE_STOP);
    end
    // restart measurement with one edge only
    restart = 1'b1;
    trig = 1'b0;
    code_a = EDGE_RISE;
    code_b = EDGE_FALL;
    apb(1'b1, ADDR_CAPTURE_CTRL, 32'h0000_0005);
    apb(1'b1, ADDR_PRESCALER_MODE, 32'h0000_0012);
    set_mode(MODE_RESTART);
    step(1'b0, 1'b1);
    step(1'b0, 1'b0);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    // a pulse seen on one sample only must be dropped
    wait_tick();
    level_a <= 1'b1;
    wait_tick();
    level_a <= 1'b0;
    repeat (3) wait_tick();
    rd(ADDR_IRQ_STATUS, 34'h0_0000_0000);
    apb(1'b1, ADDR_CAPTURE_COMPARE_B, 32'h0000_1234);
    rd(ADDR_CAPTURE_COMPARE_B, {18'h0_0000, last_b});
    // count clock from filtered input a edges, compare values out of reach
    set_mode(MODE_STOP);
    apb(1'b1, ADDR_CAPTURE_CTRL, 32'h0000_0000);
    apb(1'b1, ADDR_CAPTURE_COMPARE_A, 32'h0000_ffff);
    apb(1'b1, ADDR_CAPTURE_COMPARE_B, 32'h0000_ffff);
    apb(1'b1, ADDR_PRESCALER_MODE, 32'h0000_0013);
    set_mode(MODE_FREE);
    repeat (2) begin
      wait_tick();
      level_a <= 1'b1;
      wait_tick();
      level_a <= 1'b0;
    end
    repeat (2) wait_tick();
    rd(ADDR_MAIN_COUNTER, 34'h0_0000_0002);
    apb(1'b1, ADDR_TIMER_MODE_CTRL, 32'h0000_0003);
    rd(ADDR_TIMER_MODE_CTRL, 34'h0_0000_0000);
    repeat (4) @(posedge clk_sys_i);
    check("pending events", 34'h0_0000_0000, {2'b00, 32'(ev_q.size())});
    results();
  end
endmodule
`default_nettype wire
